// file: hw/ssc_pkg.sv
// Package of constants for the system status and control register bank
package ssc_pkg;

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [3:0] SSC_OFS_BREAK_WAIT   = 4'h0;
	localparam logic [3:0] SSC_OFS_RESET_SRC    = 4'h1;
	localparam logic [3:0] SSC_OFS_BREAK_CTRL   = 4'h2;
	localparam logic [3:0] SSC_OFS_IRQ_STATUS   = 4'h3;
	localparam logic [3:0] SSC_OFS_IRQ_MASK     = 4'h4;
	localparam logic [3:0] SSC_OFS_BREAK_STATE  = 4'h5;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int SSC_BIT_BREAK_WAIT    = 0;
	localparam int SSC_BIT_CLEAR_ENABLE  = 0;
	localparam int SSC_BIT_POWER_ON      = 7;
	localparam int SSC_BIT_PIN           = 6;
	localparam int SSC_BIT_WATCHDOG      = 5;
	localparam int SSC_BIT_ILL_OPCODE    = 4;
	localparam int SSC_BIT_ILL_ADDRESS   = 3;
	localparam int SSC_BIT_BROWNOUT      = 1;
	localparam int SSC_IRQ_BREAK_WAKE    = 0;
	localparam int SSC_IRQ_RESET_SEEN    = 1;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [7:0] SSC_RST_BREAK_WAIT  = 8'h00;
	localparam logic [7:0] SSC_RST_RESET_SRC   = 8'h80;
	localparam logic [7:0] SSC_RST_BREAK_CTRL  = 8'h00;
	localparam logic [7:0] SSC_RST_IRQ         = 8'h00;
	localparam logic [7:0] SSC_READ_UNMAPPED   = 8'h00;

	// Cause of the reset just ended
	typedef enum logic [2:0] {
		SSC_CAUSE_POWER_ON  = 3'b000,
		SSC_CAUSE_PIN       = 3'b001,
		SSC_CAUSE_WATCHDOG  = 3'b010,
		SSC_CAUSE_ILL_OP    = 3'b011,
		SSC_CAUSE_ILL_ADDR  = 3'b100,
		SSC_CAUSE_BROWNOUT  = 3'b101,
		SSC_CAUSE_NONE      = 3'b111
	} ssc_cause_t;

endpackage : ssc_pkg

// file: hw/ssc_sync.sv
// Two flop synchroniser for a single level
`timescale 1ns/100ps
`default_nettype none
module ssc_sync (
	// Clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// Level in and out
	input  wire logic din,
	output var  logic dout
);
	logic meta_q;

	// First flop only feeds the second
	always_ff @(posedge clk) begin
		if (!nrst) begin
			meta_q <= 1'b0;
			dout   <= 1'b0;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule : ssc_sync
`default_nettype wire

// file: hw/ssc_cause_latch.sv
// Captures the source of a reset while it is held and reports it at release
`timescale 1ns/100ps
`default_nettype none
module ssc_cause_latch
	import ssc_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// Synchronised cause levels
	input  wire logic       por_s,
	input  wire logic       pin_s,
	input  wire logic       wdog_s,
	input  wire logic       illegal_opcode_reset_flag_s,
	input  wire logic       illegal_address_reset_flag_s,
	input  wire logic       bod_s,
	// Cause captured, pulse on release
	output var  logic [2:0] cause,
	output var  logic       release_pulse
);
	logic held_q;

	// Cause sampled while reset holds; power-on has priority
	always_ff @(posedge clk) begin
		if (!nrst) begin
			held_q <= 1'b1;
			if (por_s)
				cause <= SSC_CAUSE_POWER_ON;
			else if (bod_s)
				cause <= SSC_CAUSE_BROWNOUT;
			else if (wdog_s)
				cause <= SSC_CAUSE_WATCHDOG;
			else if (illegal_opcode_reset_flag_s)
				cause <= SSC_CAUSE_ILL_OP;
			else if (illegal_address_reset_flag_s)
				cause <= SSC_CAUSE_ILL_ADDR;
			else if (pin_s)
				cause <= SSC_CAUSE_PIN;
			else
				cause <= SSC_CAUSE_NONE; // No stale cause from an earlier reset
			release_pulse <= 1'b0;
		end else begin
			held_q        <= 1'b0;
			release_pulse <= held_q;
		end
	end
endmodule : ssc_cause_latch
`default_nettype wire

// file: hw/ssc_regs.sv
// System status and control register bank with break flag protection
//
// Summary of operation
// - Break waking wait mode sets break-wait flag
// - Writing zero clears the break-wait flag
// - Any reset clears the break-wait flag
// - Reading reset-source register clears all flags
// - Power-on sets its flag, clears others
// - Pin reset sets pin flag
// - Watchdog reset sets watchdog flag
// - Illegal opcode reset sets its flag
// - Only illegal opcode fetch sets address flag
// - Brownout reset sets brownout flag
// - Enable set: break accesses clear flags
// - Enable clear: break accesses keep flags
// - Break clears persist; two-step stays protected
`timescale 1ns/100ps
`default_nettype none
module ssc_regs
	import ssc_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// Register port
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output var  logic [7:0] rdata,
	// Reset cause levels, held during reset
	input  wire logic       por_cause,
	input  wire logic       pin_cause,
	input  wire logic       wdog_cause,
	input  wire logic       illegal_opcode_reset_flag_cause,
	input  wire logic       illegal_address_reset_flag_cause,
	input  wire logic       illegal_address_reset_flag_is_fetch,
	input  wire logic       bod_cause,
	// Processor state
	input  wire logic       in_wait,
	input  wire logic       break_irq,
	input  wire logic       in_break,
	// Permission given to other modules to clear flags
	output var  logic       flag_clear_ok,
	output var  logic       step_clear_ok,
	// Interrupt
	output var  logic       irq
);
	// ************************************************************
	// Input synchronisers
	// ************************************************************
	// Synchronised cause levels
	logic       por_s;
	logic       pin_s;
	logic       wdog_s;
	logic       illegal_opcode_reset_flag_s;
	logic       illegal_address_reset_flag_s;
	logic       fetch_s;
	logic       bod_s;
	// Synchronised processor state
	logic       wait_s;
	logic       brk_irq_s;
	logic       brk_s;
	// Captured cause and its release strobe
	logic [2:0] cause;
	logic       rel_pulse;

	// Cause chains ignore reset: the levels must get through while reset holds
	ssc_sync u_sync_por (
		.clk  (clk),
		.nrst (1'b1),
		.din  (por_cause),
		.dout (por_s)
	);

	ssc_sync u_sync_pin (
		.clk  (clk),
		.nrst (1'b1),
		.din  (pin_cause),
		.dout (pin_s)
	);

	ssc_sync u_sync_wdog (
		.clk  (clk),
		.nrst (1'b1),
		.din  (wdog_cause),
		.dout (wdog_s)
	);

	ssc_sync u_sync_illegal_opcode_reset_flag (
		.clk  (clk),
		.nrst (1'b1),
		.din  (illegal_opcode_reset_flag_cause),
		.dout (illegal_opcode_reset_flag_s)
	);

	ssc_sync u_sync_illegal_address_reset_flag (
		.clk  (clk),
		.nrst (1'b1),
		.din  (illegal_address_reset_flag_cause),
		.dout (illegal_address_reset_flag_s)
	);

	ssc_sync u_sync_fetch (
		.clk  (clk),
		.nrst (1'b1),
		.din  (illegal_address_reset_flag_is_fetch),
		.dout (fetch_s)
	);

	ssc_sync u_sync_bod (
		.clk  (clk),
		.nrst (1'b1),
		.din  (bod_cause),
		.dout (bod_s)
	);

	// State chains clear in reset, so a wake seen before a reset
	// cannot set the flag after it
	ssc_sync u_sync_wait (
		.clk  (clk),
		.nrst (nrst),
		.din  (in_wait),
		.dout (wait_s)
	);

	ssc_sync u_sync_bi (
		.clk  (clk),
		.nrst (nrst),
		.din  (break_irq),
		.dout (brk_irq_s)
	);

	ssc_sync u_sync_brk (
		.clk  (clk),
		.nrst (nrst),
		.din  (in_break),
		.dout (brk_s)
	);

	// Cause capture; address flag only counts opcode fetches
	// An illegal address hit from a data access leaves no mark
	ssc_cause_latch u_cause (
		.clk           (clk),
		.nrst          (nrst),
		.por_s         (por_s),
		.pin_s         (pin_s),
		.wdog_s        (wdog_s),
		.illegal_opcode_reset_flag_s        (illegal_opcode_reset_flag_s),
		.illegal_address_reset_flag_s        (illegal_address_reset_flag_s & fetch_s),
		.bod_s         (bod_s),
		.cause         (cause),
		.release_pulse (rel_pulse)
	);

	// ************************************************************
	// Access decode
	// ************************************************************
	// Every access completes in one cycle; the bus never waits
	// Index compare shared by every strobe
	function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	// Strobes qualified by register index
	logic wr_bw;
	logic wr_ctl;
	logic wr_ist;
	logic wr_msk;
	logic rd_src;
	assign wr_bw  = wr && hit(addr, SSC_OFS_BREAK_WAIT);
	assign wr_ctl = wr && hit(addr, SSC_OFS_BREAK_CTRL);
	assign wr_ist = wr && hit(addr, SSC_OFS_IRQ_STATUS);
	assign wr_msk = wr && hit(addr, SSC_OFS_IRQ_MASK);
	assign rd_src = rd && hit(addr, SSC_OFS_RESET_SRC);

	// ************************************************************
	// Break-wait flag
	// ************************************************************
	// Tells the break handler that wait mode was cut short
	logic bw_q;
	logic bw_d;
	logic wake_ev;
	// Break while waiting; both levels are synchronised first
	assign wake_ev = brk_irq_s && wait_s;

	// Next value; a wake in the same cycle as a write of zero wins
	always_comb begin
		bw_d = bw_q;
		if (wr_bw && !wdata[SSC_BIT_BREAK_WAIT])
			bw_d = 1'b0;
		if (wake_ev)
			bw_d = 1'b1;
	end

	// Flag register, cleared by every kind of reset
	always_ff @(posedge clk) begin
		if (!nrst)
			bw_q <= SSC_RST_BREAK_WAIT[0];
		else
			bw_q <= bw_d;
	end

	// ************************************************************
	// Reset source flags
	// ************************************************************
	// Flags record the cause of the last reset and clear on a read
	logic [7:0] src_q;
	logic [7:0] src_d;
	logic [7:0] cause_bits;

	// One-hot flag image of the captured cause
	always_comb begin
		cause_bits = 8'h00;
		unique case (cause)
			SSC_CAUSE_POWER_ON: cause_bits[SSC_BIT_POWER_ON]    = 1'b1;
			SSC_CAUSE_PIN:      cause_bits[SSC_BIT_PIN]         = 1'b1;
			SSC_CAUSE_WATCHDOG: cause_bits[SSC_BIT_WATCHDOG]    = 1'b1;
			SSC_CAUSE_ILL_OP:   cause_bits[SSC_BIT_ILL_OPCODE]  = 1'b1;
			SSC_CAUSE_ILL_ADDR: cause_bits[SSC_BIT_ILL_ADDRESS] = 1'b1;
			SSC_CAUSE_BROWNOUT: cause_bits[SSC_BIT_BROWNOUT]    = 1'b1;
			default:            cause_bits = 8'h00;
		endcase
	end

	// Next value; the update at release beats a read in the same cycle
	always_comb begin
		src_d = src_q;
		if (rd_src)
			src_d = 8'h00;
		if (rel_pulse)
			src_d = (cause == SSC_CAUSE_POWER_ON) ? cause_bits
			        : (src_q | cause_bits);
	end

	// Contents survive a non power-on reset, so software still sees older
	// flags after a watchdog or pin reset; only power-on starts afresh
	always_ff @(posedge clk) begin
		if (!nrst && por_s)
			src_q <= SSC_RST_RESET_SRC;
		else if (nrst)
			src_q <= src_d;
	end

	// ************************************************************
	// Break flag control and protection outputs
	// ************************************************************
	// The enable decides whether other modules may make single-step flag clears in break; two-step clears stay blocked
	logic break_clear_enable_q;

	// Clear enable bit, software owned
	always_ff @(posedge clk) begin
		if (!nrst)
			break_clear_enable_q <= SSC_RST_BREAK_CTRL[0];
		else if (wr_ctl)
			break_clear_enable_q <= wdata[SSC_BIT_CLEAR_ENABLE];
	end

	// Single-step clears: free outside break, gated by the enable inside it
	always_ff @(posedge clk) begin
		if (!nrst)
			flag_clear_ok <= 1'b1;
		else
			flag_clear_ok <= !brk_s || break_clear_enable_q;
	end

	// Two-step clears: blocked for the whole break, so a first step taken
	// before break cannot complete inside it
	always_ff @(posedge clk) begin
		if (!nrst)
			step_clear_ok <= 1'b1;
		else
			step_clear_ok <= !brk_s;
	end

	// ************************************************************
	// Interrupt status and mask
	// ************************************************************
	// Status bits are sticky and cleared by writing one
	logic [1:0] ist_q;
	logic [1:0] ist_d;
	logic [1:0] msk_q;

	// Next status; an event beats a write-one clear in the same cycle
	always_comb begin
		ist_d = ist_q;
		if (wr_ist)
			ist_d = ist_q & ~wdata[1:0];
		if (wake_ev)
			ist_d[SSC_IRQ_BREAK_WAKE] = 1'b1;
		if (rel_pulse)
			ist_d[SSC_IRQ_RESET_SEEN] = 1'b1;
	end

	// Sticky interrupt status
	always_ff @(posedge clk) begin
		if (!nrst)
			ist_q <= SSC_RST_IRQ[1:0];
		else
			ist_q <= ist_d;
	end

	// Interrupt mask, software owned, same layout as status
	always_ff @(posedge clk) begin
		if (!nrst)
			msk_q <= SSC_RST_IRQ[1:0];
		else if (wr_msk)
			msk_q <= wdata[1:0];
	end

	// Level interrupt; uses the next status so a new event shows a cycle sooner
	always_ff @(posedge clk) begin
		if (!nrst)
			irq <= 1'b0;
		else
			irq <= |(ist_d & msk_q);
	end

	// ************************************************************
	// Read data, one cycle after the strobe
	// ************************************************************
	// Data stands only in the cycle after the strobe, zero otherwise
	// Indexes outside the map read as zero
	always_ff @(posedge clk) begin
		if (!nrst)
			rdata <= SSC_READ_UNMAPPED;
		else if (rd) begin
			unique case (addr)
				SSC_OFS_BREAK_WAIT:  rdata <= {7'h00, bw_q};
				SSC_OFS_RESET_SRC:   rdata <= src_q;
				SSC_OFS_BREAK_CTRL:  rdata <= {7'h00, break_clear_enable_q};
				SSC_OFS_IRQ_STATUS:  rdata <= {6'h00, ist_q};
				SSC_OFS_IRQ_MASK:    rdata <= {6'h00, msk_q};
				SSC_OFS_BREAK_STATE: rdata <= {7'h00, brk_s};
				default:             rdata <= SSC_READ_UNMAPPED;
			endcase
		end else
			rdata <= SSC_READ_UNMAPPED;
	end
endmodule : ssc_regs
`default_nettype wire

// file: test/ssc_regs_asserts.sv
// Port checker for the register bank
`timescale 1ns/100ps
`default_nettype none
module ssc_regs_chk
	import ssc_pkg::*;
(
	// Clock and reset
	input wire logic       clk,
	input wire logic       nrst,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	// Causes
	input wire logic       por_cause,
	input wire logic       pin_cause,
	input wire logic       wdog_cause,
	input wire logic       illegal_opcode_reset_flag_cause,
	input wire logic       illegal_address_reset_flag_cause,
	input wire logic       illegal_address_reset_flag_is_fetch,
	input wire logic       bod_cause,
	// Processor state and permissions
	input wire logic       in_wait,
	input wire logic       break_irq,
	input wire logic       in_break,
	input wire logic       flag_clear_ok,
	input wire logic       step_clear_ok
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	logic [3:0] up_q;
	logic [2:0] wk_q;
	logic       clr_q;
	logic [7:0] cap_q;
	// **********
	// Helpers
	// **********
	// Cycles since release, source read seen, causes held in reset
	always_ff @(posedge clk) begin
		if (!nrst) begin
			up_q  <= 4'h0;
			clr_q <= 1'b0;
			cap_q <= {por_cause, pin_cause, wdog_cause, illegal_opcode_reset_flag_cause,
				illegal_address_reset_flag_cause & illegal_address_reset_flag_is_fetch, 1'b0, bod_cause, 1'b0};
		end else begin
			if (up_q != 4'hf) up_q <= up_q + 4'h1;
			if (rd && addr == SSC_OFS_RESET_SRC && up_q > 4'h2) clr_q <= 1'b1;
		end
	end
	// Cycles with break waking wait mode
	always_ff @(posedge clk) begin
		if (!nrst || !(in_wait && break_irq)) wk_q <= 3'h0;
		else if (wk_q != 3'h7) wk_q <= wk_q + 3'h1;
	end
	// **********
	// Properties
	// **********
	chk_idle_rdata: assert property (!$past(rd) |-> rdata == 8'h00) else $error("rdata not zero");
	chk_unmapped_zero: assert property (rd && addr > SSC_OFS_BREAK_STATE |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	chk_wake_sets: assert property (rd && addr == SSC_OFS_BREAK_WAIT && wk_q > 3'h3 |=> rdata[0])
		else $error("break wait not set");
	chk_zero_clears: assert property ((!break_irq)[*4] ##0 (wr && addr == SSC_OFS_BREAK_WAIT &&
		!wdata[0]) ##1 (rd && addr == SSC_OFS_BREAK_WAIT) |=> !rdata[0]) else $error("flag kept");
	chk_read_clears: assert property (clr_q && rd && addr == SSC_OFS_RESET_SRC |=> rdata == 8'h00)
		else $error("source not cleared");
	chk_por_value: assert property (cap_q[7] && !clr_q && up_q > 4'h2 && rd &&
		addr == SSC_OFS_RESET_SRC |=> (rdata & 8'hfa) == 8'h80) else $error("power on flags");
	chk_own_flag: assert property (!cap_q[7] && !clr_q && up_q > 4'h2 && rd &&
		addr == SSC_OFS_RESET_SRC |=> (rdata & cap_q) == cap_q) else $error("cause flag missing");
	chk_free_outside: assert property ((!in_break)[*4] |=> flag_clear_ok)
		else $error("clear blocked outside break");
	chk_break_step: assert property (in_break[*4] |=> !step_clear_ok)
		else $error("two step clear in break");
	cover property (cap_q[7] && rd && addr == SSC_OFS_RESET_SRC);
	cover property (in_break && !flag_clear_ok);
	cover property (wk_q > 3'h3 && rd);
endmodule : ssc_regs_chk
bind ssc_regs ssc_regs_chk u_chk (.*);
`default_nettype wire

// file: test/tb_top.sv
// Testbench of the register bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import ssc_pkg::*;
	logic       clk, nrst, wr, rd, in_wait, break_irq, in_break, irq, fc_ok, st_ok;
	logic [3:0] addr;
	logic [7:0] wdata, rdata;
	logic [6:0] cause;
	int         errors, total_checks;
	logic [6:0] tc [6] = '{7'h20, 7'h10, 7'h08, 7'h06, 7'h04, 7'h01};
	logic [7:0] te [6] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h00, 8'h02};
	ssc_regs uut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .por_cause(cause[6]), .pin_cause(cause[5]), .wdog_cause(cause[4]),
		.illegal_opcode_reset_flag_cause(cause[3]), .illegal_address_reset_flag_cause(cause[2]), .illegal_address_reset_flag_is_fetch(cause[1]),
		.bod_cause(cause[0]), .in_wait(in_wait), .break_irq(break_irq), .in_break(in_break),
		.flag_clear_ok(fc_ok), .step_clear_ok(st_ok), .irq(irq));
	// **********
	// Tasks
	// **********
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			$display("unexpected %s exp %h got %h", n, e, g);
			errors++;
		end
	endtask : chk
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e, string n);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(n, e, rdata & m);
		@(posedge clk);
	endtask : rd_reg
	task automatic rst(input logic [6:0] c);
		nrst <= 1'b0;
		cause <= c;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		cause <= 7'h00;
		repeat (4) @(posedge clk);
	endtask : rst
	task automatic ok_chk(input logic f, input logic s);
		repeat (5) @(negedge clk);
		chk("clear permission", {6'h0, f, s}, {6'h0, fc_ok, st_ok});
		@(posedge clk);
	endtask : ok_chk
	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim
	// **********
	// Clock, watchdog and tests
	// **********
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		#200000;
		errors++;
		end_sim();
	end
	initial begin
		{nrst, wr, rd, addr, wdata, cause, in_wait, break_irq, in_break} = '0;
		rst(7'h40);
		rd_reg(SSC_OFS_RESET_SRC, 8'hfa, 8'h80, "power on flags");
		rd_reg(SSC_OFS_RESET_SRC, 8'hff, 8'h00, "source after read");
		for (int i = 0; i < 6; i++) begin
			rst(tc[i]);
			rd_reg(SSC_OFS_RESET_SRC, 8'hfa, te[i], "source flags");
		end
		in_wait <= 1'b1;
		break_irq <= 1'b1;
		repeat (6) @(posedge clk);
		rd_reg(SSC_OFS_BREAK_WAIT, 8'h01, 8'h01, "break wait");
		rd_reg(SSC_OFS_IRQ_STATUS, 8'h01, 8'h01, "wake event");
		wr_reg(SSC_OFS_IRQ_MASK, 8'h00);
		repeat (2) @(negedge clk);
		chk("irq masked", 8'h00, {7'h0, irq});
		@(posedge clk);
		wr_reg(SSC_OFS_IRQ_MASK, 8'hff);
		repeat (2) @(negedge clk);
		chk("irq unmasked", 8'h01, {7'h0, irq});
		@(posedge clk);
		in_wait <= 1'b0;
		break_irq <= 1'b0;
		repeat (5) @(posedge clk);
		wr_reg(SSC_OFS_IRQ_STATUS, 8'h03);
		rd_reg(SSC_OFS_IRQ_STATUS, 8'h03, 8'h00, "events cleared");
		@(negedge clk);
		chk("irq idle", 8'h00, {7'h0, irq});
		@(posedge clk);
		wr_reg(SSC_OFS_BREAK_WAIT, 8'h00);
		rd_reg(SSC_OFS_BREAK_WAIT, 8'h01, 8'h00, "break wait cleared");
		in_wait <= 1'b1;
		break_irq <= 1'b1;
		repeat (6) @(posedge clk);
		in_wait <= 1'b0;
		break_irq <= 1'b0;
		rd_reg(SSC_OFS_BREAK_WAIT, 8'h01, 8'h01, "break wait again");
		rst(7'h20);
		rd_reg(SSC_OFS_BREAK_WAIT, 8'h01, 8'h00, "break wait after reset");
		wr_reg(SSC_OFS_BREAK_CTRL, 8'h01);
		rd_reg(SSC_OFS_BREAK_CTRL, 8'h01, 8'h01, "clear enable");
		in_break <= 1'b1;
		ok_chk(1'b1, 1'b0);
		wr_reg(SSC_OFS_BREAK_CTRL, 8'h00);
		ok_chk(1'b0, 1'b0);
		rd_reg(SSC_OFS_BREAK_STATE, 8'h01, 8'h01, "break state");
		in_break <= 1'b0;
		ok_chk(1'b1, 1'b1);
		wr_reg(4'hf, 8'hff);
		rd_reg(4'hf, 8'hff, 8'h00, "unmapped");
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
